// ---- logic/atast_pkg.sv ----
// package: register map, field layout and types of the ata strobe timer
package atast_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ATAST_OFF_MISC   = 8'h00;
    localparam logic [7:0] ATAST_OFF_PIOSTB = 8'h04;
    localparam logic [7:0] ATAST_OFF_PIORCV = 8'h08;
    localparam logic [7:0] ATAST_OFF_MDMA_STROBE_WIDTH = 8'h0C;
    localparam logic [7:0] ATAST_OFF_DMARCV = 8'h10;
    localparam logic [7:0] ATAST_OFF_CMD    = 8'h14;
    localparam logic [7:0] ATAST_OFF_STAT   = 8'h18;
    localparam logic [7:0] ATAST_OFF_WDATA  = 8'h1C;
    localparam logic [7:0] ATAST_OFF_RDATA  = 8'h20;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int ATAST_CW        = 8;  // width of every timing count
    localparam int ATAST_MISC_EN   = 0;  // timing override enable bit
    localparam int ATAST_MISC_HLD  = 8;  // hold count low bit
    localparam int ATAST_CMD_WR    = 0;  // 1 = write access
    localparam int ATAST_CMD_DMA   = 1;  // 1 = multiword dma, 0 = pio
    localparam int ATAST_ST_BUSY   = 0;
    localparam int ATAST_ST_DONE   = 1;

    localparam logic [1:0]  ATAST_RESP_OK  = 2'h0;
    localparam logic [1:0]  ATAST_RESP_ERR = 2'h2;
    localparam logic [7:0]  ATAST_CNT_RST  = 8'h00;
    localparam logic [31:0] ATAST_ZERO32   = 32'h00000000;

    // timing set handed to the sequencer
    typedef struct packed {
        logic [ATAST_CW-1:0] strobe;
        logic [ATAST_CW-1:0] recover;
        logic [ATAST_CW-1:0] hold;
    } atast_timing_t;

    typedef enum logic [3:0] {
        ATAST_IDLE = 4'b0001,
        ATAST_STRB = 4'b0010,
        ATAST_HOLD = 4'b0100,
        ATAST_RCVR = 4'b1000
    } atast_state_t;
endpackage

// ---- logic/atast_seq.sv ----
// strobe sequencer: strobe, write hold, recovery for one access
`timescale 1ns/10ps
module atast_seq
    import atast_pkg::*;
(
    input  wire logic          clk,      // controller clock
    input  wire logic          nrst,     // async reset, active low
    input  wire logic          start,    // start one access, pulse
    input  wire logic          is_write, // access direction
    input  wire atast_timing_t tim,      // counts, minus-one encoded
    output logic               strobe,   // read or write strobe active
    output logic               wdrive,   // write data driven
    output logic               busy,     // access under way
    output logic               done      // access complete, pulse
);
    atast_state_t        st_q, st_d;
    logic [ATAST_CW-1:0] cnt_q, cnt_d;
    logic                wr_q, wr_d;

    // next state; a count of n runs n+1 cycles
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        wr_d  = wr_q;
        done  = 1'b0;
        unique case (st_q)
            ATAST_IDLE: begin
                if (start) begin
                    st_d  = ATAST_STRB;
                    cnt_d = tim.strobe;
                    wr_d  = is_write;
                end
            end
            ATAST_STRB: begin
                if (cnt_q != ATAST_CNT_RST) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (wr_q) begin
                    st_d  = ATAST_HOLD;
                    cnt_d = tim.hold;
                end else begin
                    st_d  = ATAST_RCVR;
                    cnt_d = tim.recover;
                end
            end
            ATAST_HOLD: begin
                if (cnt_q != ATAST_CNT_RST) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    st_d  = ATAST_RCVR;
                    cnt_d = tim.recover;
                end
            end
            ATAST_RCVR: begin
                if (cnt_q != ATAST_CNT_RST) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    st_d = ATAST_IDLE;
                    done = 1'b1;
                end
            end
            default: begin
                st_d = ATAST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q  <= ATAST_IDLE;
            cnt_q <= ATAST_CNT_RST;
            wr_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            wr_q  <= wr_d;
        end
    end

    assign strobe = (st_q == ATAST_STRB);
    assign wdrive = wr_q & (st_q != ATAST_IDLE) & (st_q != ATAST_RCVR);
    assign busy   = (st_q != ATAST_IDLE);
endmodule

// ---- logic/atast_top.sv ----
// ata pio / multiword dma strobe timing block with axi4-lite registers
`timescale 1ns/10ps
module atast_top
    import atast_pkg::*;
(
    input  wire logic        clk,          // 40 MHz controller clock
    input  wire logic        nrst,         // async reset, active low
    input  wire logic [7:0]  s_axi_awaddr, // write address
    input  wire logic        s_axi_awvalid,// write address valid
    output logic             s_axi_awready,// write address ready
    input  wire logic [31:0] s_axi_wdata,  // write data
    input  wire logic [3:0]  s_axi_wstrb,  // write byte enables
    input  wire logic        s_axi_wvalid, // write data valid
    output logic             s_axi_wready, // write data ready
    output logic [1:0]       s_axi_bresp,  // write response
    output logic             s_axi_bvalid, // write response valid
    input  wire logic        s_axi_bready, // write response ready
    input  wire logic [7:0]  s_axi_araddr, // read address
    input  wire logic        s_axi_arvalid,// read address valid
    output logic             s_axi_arready,// read address ready
    output logic [31:0]      s_axi_rdata,  // read data
    output logic [1:0]       s_axi_rresp,  // read response
    output logic             s_axi_rvalid, // read data valid
    input  wire logic        s_axi_rready, // read data ready
    output logic             rd_strobe_n,  // read strobe to disk, low
    output logic             wr_strobe_n,  // write strobe to disk, low
    output logic [15:0]      dd_out,       // data bus out
    output logic             dd_oe,        // data bus output enable
    input  wire logic [15:0] dd_in         // data bus in, from pins
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic                timing_override_enable_q, en_d;
    logic [ATAST_CW-1:0] write_data_hold_count_q, hld_d;
    logic [ATAST_CW-1:0] pio_data_strobe_width_q, pst_d;
    logic [ATAST_CW-1:0] pio_data_recovery_count_q, prc_d;
    logic [ATAST_CW-1:0] mdma_strobe_width_q, dst_d;
    logic [ATAST_CW-1:0] mdma_recovery_count_q, drc_d;
    logic [15:0]         wdat_q, wdat_d;
    logic [15:0]         rdat_q, rdat_d;
    logic [15:0]         din_s1_q, din_s2_q;
    logic                done_q, done_d;
    logic                dma_q, dma_d;
    logic                aw_q, aw_d, w_q, w_d, bv_q, bv_d;
    logic [7:0]          awa_q, awa_d;
    logic [31:0]         wd_q, wd_d;
    logic [1:0]          br_q, br_d;
    logic                rv_q, rv_d;
    logic [31:0]         rd_q, rd_d;
    logic [1:0]          rr_q, rr_d;
    logic                st_go, st_wr;
    logic                rds_q, rds_d, wrs_q, wrs_d, oe_q, oe_d;
    logic                seq_strobe, seq_wdrive, seq_busy, seq_done;
    logic                seq_wr_q, seq_wr_d;
    atast_timing_t       tim;
    logic [31:0]         misc_word;

    // ------------------------------------------------------------------
    // timing selection
    // ------------------------------------------------------------------
    // with the override off the counts fall back to zero (one cycle),
    // which is too fast for real disks: software must set the enable
    always_comb begin
        tim.hold = timing_override_enable_q ? write_data_hold_count_q
                                            : ATAST_CNT_RST;
        if (!timing_override_enable_q) begin
            tim.strobe  = ATAST_CNT_RST;
            tim.recover = ATAST_CNT_RST;
        end else if (dma_d) begin          // mode of a start in flight
            tim.strobe  = mdma_strobe_width_q;
            tim.recover = mdma_recovery_count_q;
        end else begin
            tim.strobe  = pio_data_strobe_width_q;
            tim.recover = pio_data_recovery_count_q;
        end
    end

    atast_seq u_seq (
        .clk      (clk),
        .nrst     (nrst),
        .start    (st_go),
        .is_write (st_wr),
        .tim      (tim),
        .strobe   (seq_strobe),
        .wdrive   (seq_wdrive),
        .busy     (seq_busy),
        .done     (seq_done)
    );

    assign misc_word = {16'h0000, write_data_hold_count_q, 7'h00,
                        timing_override_enable_q};

    // ------------------------------------------------------------------
    // axi4-lite write channel and register writes
    // ------------------------------------------------------------------
    // address and data are caught in either order; response follows both
    always_comb begin
        aw_d  = aw_q;
        awa_d = awa_q;
        w_d   = w_q;
        wd_d  = wd_q;
        bv_d  = bv_q;
        br_d  = br_q;
        en_d  = timing_override_enable_q;
        hld_d = write_data_hold_count_q;
        pst_d = pio_data_strobe_width_q;
        prc_d = pio_data_recovery_count_q;
        dst_d = mdma_strobe_width_q;
        drc_d = mdma_recovery_count_q;
        wdat_d = wdat_q;
        dma_d  = dma_q;
        st_go  = 1'b0;
        st_wr  = 1'b0;
        if (s_axi_awvalid && !aw_q && !bv_q) begin
            aw_d  = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q && !bv_q) begin
            w_d  = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (aw_q && w_q) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = ATAST_RESP_OK;
            unique case (awa_q)
                ATAST_OFF_MISC: begin
                    if (s_axi_wstrb[0]) en_d = wd_q[ATAST_MISC_EN];
                    if (s_axi_wstrb[1])
                        hld_d = wd_q[ATAST_MISC_HLD +: ATAST_CW];
                end
                ATAST_OFF_PIOSTB: if (s_axi_wstrb[0]) pst_d = wd_q[7:0];
                ATAST_OFF_PIORCV: if (s_axi_wstrb[0]) prc_d = wd_q[7:0];
                ATAST_OFF_MDMA_STROBE_WIDTH: if (s_axi_wstrb[0]) dst_d = wd_q[7:0];
                ATAST_OFF_DMARCV: if (s_axi_wstrb[0]) drc_d = wd_q[7:0];
                ATAST_OFF_WDATA:  wdat_d = wd_q[15:0];
                ATAST_OFF_CMD: begin
                    // a start while busy is dropped and answered slverr
                    if (seq_busy) begin
                        br_d = ATAST_RESP_ERR;
                    end else begin
                        st_go = 1'b1;
                        st_wr = wd_q[ATAST_CMD_WR];
                        dma_d = wd_q[ATAST_CMD_DMA];
                    end
                end
                ATAST_OFF_STAT, ATAST_OFF_RDATA: ;
                default: br_d = ATAST_RESP_ERR;
            endcase
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    always_comb begin
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = ATAST_RESP_OK;
            rd_d = ATAST_ZERO32;
            unique case (s_axi_araddr)
                ATAST_OFF_MISC:   rd_d = misc_word;
                ATAST_OFF_PIOSTB: rd_d[7:0] = pio_data_strobe_width_q;
                ATAST_OFF_PIORCV: rd_d[7:0] = pio_data_recovery_count_q;
                ATAST_OFF_MDMA_STROBE_WIDTH: rd_d[7:0] = mdma_strobe_width_q;
                ATAST_OFF_DMARCV: rd_d[7:0] = mdma_recovery_count_q;
                ATAST_OFF_CMD:    rd_d[ATAST_CMD_DMA] = dma_q;
                ATAST_OFF_STAT: begin
                    rd_d[ATAST_ST_BUSY] = seq_busy;
                    rd_d[ATAST_ST_DONE] = done_q;
                end
                ATAST_OFF_WDATA:  rd_d[15:0] = wdat_q;
                ATAST_OFF_RDATA:  rd_d[15:0] = rdat_q;
                default:          rr_d = ATAST_RESP_ERR;
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // pin side: strobes, data drive, read capture, done flag
    // ------------------------------------------------------------------
    // read data is latched at the last strobe cycle; sticky done is set by
    // the sequencer and cleared by reading status, the set wins
    always_comb begin
        seq_wr_d = st_go ? st_wr : seq_wr_q;
        rds_d    = seq_strobe & ~seq_wr_q;
        wrs_d    = seq_strobe & seq_wr_q;
        oe_d     = seq_wdrive;
        rdat_d   = (seq_strobe && !seq_wr_q) ? din_s2_q : rdat_q;
        done_d   = done_q;
        if (s_axi_arvalid && !rv_q && s_axi_araddr == ATAST_OFF_STAT)
            done_d = 1'b0;
        if (st_go)
            done_d = 1'b0;
        if (seq_done)
            done_d = 1'b1;
    end

    // all registers of the block
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timing_override_enable_q  <= 1'b0;
            write_data_hold_count_q   <= ATAST_CNT_RST;
            pio_data_strobe_width_q   <= ATAST_CNT_RST;
            pio_data_recovery_count_q <= ATAST_CNT_RST;
            mdma_strobe_width_q       <= ATAST_CNT_RST;
            mdma_recovery_count_q     <= ATAST_CNT_RST;
            wdat_q   <= 16'h0000;
            rdat_q   <= 16'h0000;
            din_s1_q <= 16'h0000;
            din_s2_q <= 16'h0000;
            done_q   <= 1'b0;
            dma_q    <= 1'b0;
            aw_q     <= 1'b0;
            awa_q    <= 8'h00;
            w_q      <= 1'b0;
            wd_q     <= ATAST_ZERO32;
            bv_q     <= 1'b0;
            br_q     <= ATAST_RESP_OK;
            rv_q     <= 1'b0;
            rd_q     <= ATAST_ZERO32;
            rr_q     <= ATAST_RESP_OK;
            seq_wr_q <= 1'b0;
            rds_q    <= 1'b0;
            wrs_q    <= 1'b0;
            oe_q     <= 1'b0;
        end else begin
            timing_override_enable_q  <= en_d;
            write_data_hold_count_q   <= hld_d;
            pio_data_strobe_width_q   <= pst_d;
            pio_data_recovery_count_q <= prc_d;
            mdma_strobe_width_q       <= dst_d;
            mdma_recovery_count_q     <= drc_d;
            wdat_q   <= wdat_d;
            rdat_q   <= rdat_d;
            din_s1_q <= dd_in;
            din_s2_q <= din_s1_q;
            done_q   <= done_d;
            dma_q    <= dma_d;
            aw_q     <= aw_d;
            awa_q    <= awa_d;
            w_q      <= w_d;
            wd_q     <= wd_d;
            bv_q     <= bv_d;
            br_q     <= br_d;
            rv_q     <= rv_d;
            rd_q     <= rd_d;
            rr_q     <= rr_d;
            seq_wr_q <= seq_wr_d;
            rds_q    <= rds_d;
            wrs_q    <= wrs_d;
            oe_q     <= oe_d;
        end
    end

    assign s_axi_awready = ~aw_q & ~bv_q;
    assign s_axi_wready  = ~w_q & ~bv_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = br_q;
    assign s_axi_arready = ~rv_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rdata   = rd_q;
    assign s_axi_rresp   = rr_q;
    assign rd_strobe_n   = ~rds_q;
    assign wr_strobe_n   = ~wrs_q;
    assign dd_out        = wdat_q;
    assign dd_oe         = oe_q;
endmodule

// ---- tb/atast_top_chk.sv ----
// checker: port-level assertions for the ata strobe timer
`timescale 1ns/10ps
module atast_top_chk (
    input wire logic clk,           // controller clock
    input wire logic nrst,          // async reset, active low
    input wire logic s_axi_awvalid, // write address valid
    input wire logic s_axi_awready, // write address ready
    input wire logic s_axi_wvalid,  // write data valid
    input wire logic s_axi_wready,  // write data ready
    input wire logic s_axi_bvalid,  // write response valid
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic s_axi_rvalid,  // read data valid
    input wire logic rd_strobe_n,   // read strobe, low
    input wire logic wr_strobe_n,   // write strobe, low
    input wire logic dd_oe          // data bus output enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence strobes_idle;
        rd_strobe_n && wr_strobe_n;
    endsequence
    // a new start needs a register write, so three quiet cycles are safe for a recovery count of 1 or more
    wr_resp_a:
    assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    b_blocks_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_resp_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    strobe_excl_a:
    assert property (strobes_idle or (rd_strobe_n ^ wr_strobe_n))
        else $error("both strobes low");
    wr_drive_a:
    assert property (!wr_strobe_n |-> dd_oe)
        else $error("write strobe without data drive");
    rd_float_a:
    assert property (!rd_strobe_n |-> !dd_oe)
        else $error("data driven during read strobe");
    hold_min_a:
    assert property ($rose(wr_strobe_n) |-> dd_oe)
        else $error("write data dropped with strobe");
    rcv_gap_a:
    assert property ($fell(dd_oe) |-> strobes_idle [*3])
        else $error("strobe inside recovery");
endmodule

bind atast_top atast_top_chk u_atast_top_chk (
    .clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .rd_strobe_n(rd_strobe_n),
    .wr_strobe_n(wr_strobe_n), .dd_oe(dd_oe)
);

// ---- tb/atast_disk_mdl.sv ----
// partner model: attached disk answering on the 16-bit data bus
`timescale 1ns/10ps
module atast_disk_mdl (
    input  wire logic        rd_strobe_n, // read strobe from host
    input  wire logic        wr_strobe_n, // write strobe from host
    input  wire logic [15:0] dd_out,      // host data out
    input  wire logic        dd_oe,       // host drives bus
    input  wire logic [15:0] word,        // word the disk returns
    output logic      [15:0] dd_in,       // resolved bus level
    output logic      [15:0] last_wr      // word latched at strobe end
);
    // bus level: host wins when enabled, released bus shows word under read strobe, else the inverse
    assign dd_in = dd_oe ? dd_out : (!rd_strobe_n ? word : ~word);
    // disk takes the bus level on the trailing strobe edge, so a host
    // that drops its drive with the strobe hands over a wrong word
    always @(posedge wr_strobe_n) last_wr <= dd_in;
endmodule

// ---- tb/ata_pio_mdma_strobe_timing_tb.sv ----
// testbench: register bus, strobe widths, hold and recovery checks
`timescale 1ns/10ps
module ata_pio_mdma_strobe_timing_tb import atast_pkg::*;;
    logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, rd_strobe_n;
    logic wr_strobe_n, dd_oe;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] dd_out, dd_in, word, last_wr;
    int          errors, samples_checked;
    atast_top u_atast_top (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rd_strobe_n,
        .wr_strobe_n, .dd_out, .dd_oe, .dd_in);
    atast_disk_mdl u_atast_disk_mdl (.rd_strobe_n, .wr_strobe_n, .dd_out,
        .dd_oe, .word, .dd_in, .last_wr);
    // ------------------------------------------------------------------
    // clock, watchdog, closing
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // whole run is a few hundred cycles, so 20000 means a hang
    initial begin
        #500000;
        errors++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ------------------------------------------------------------------
    // bus tasks: called just after a rising edge
    // ------------------------------------------------------------------
    // bready and rready stay high once raised, so back-to-back calls
    // never lower and raise them in one time step; only the watchdog
    // ends a wait for an answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // program one access, start it, measure strobe and hold cycles
    task automatic do_access(input logic dma, wr, en,
                             input logic [7:0] s, r, h,
                             input logic [15:0] d, output int ns, nh);
        logic [1:0] rs;
        int n;
        ns = 0;
        nh = 0;
        n = 0;
        axi_wr(ATAST_OFF_MISC, {16'h0000, h, 7'h00, en}, rs);
        axi_wr(dma ? ATAST_OFF_MDMA_STROBE_WIDTH : ATAST_OFF_PIOSTB, {24'h0, s}, rs);
        axi_wr(dma ? ATAST_OFF_DMARCV : ATAST_OFF_PIORCV, {24'h0, r}, rs);
        axi_wr(ATAST_OFF_WDATA, {16'h0000, d}, rs);
        axi_wr(ATAST_OFF_CMD, {30'h0, dma, wr}, rs);
        check("start response", rs, ATAST_RESP_OK);
        while ((wr ? wr_strobe_n : rd_strobe_n) && n < 50) begin
            @(posedge clk);
            n++;
        end
        while (!(wr ? wr_strobe_n : rd_strobe_n) && ns < 300) begin
            if (wr) check("write data", dd_out, d);
            ns++;
            @(posedge clk);
        end
        while (dd_oe && nh < 300) begin
            nh++;
            @(posedge clk);
        end
    endtask
    // start refused in recovery, then done shows once recovery ends
    task automatic recover_chk(input bit refuse);
        logic [1:0]  rs;
        logic [31:0] st;
        if (refuse) begin
            axi_wr(ATAST_OFF_CMD, 32'h00000001, rs);
            check("start in recovery", rs, ATAST_RESP_ERR);
        end
        repeat (40) @(posedge clk);
        axi_rd(ATAST_OFF_STAT, st, rs);
        check("status done", st, 32'h00000002);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic sc_reset_vals();
        logic [7:0]  offs [6];
        logic [31:0] d;
        logic [1:0]  rs;
        offs = '{ATAST_OFF_MISC, ATAST_OFF_PIOSTB, ATAST_OFF_PIORCV,
                 ATAST_OFF_MDMA_STROBE_WIDTH, ATAST_OFF_DMARCV, ATAST_OFF_STAT};
        foreach (offs[i]) begin
            axi_rd(offs[i], d, rs);
            check("reset value", d, ATAST_ZERO32);
        end
    endtask
    task automatic sc_unmapped();
        logic [31:0] d;
        logic [1:0]  rs;
        axi_wr(8'h24, 32'hFFFFFFFF, rs);
        check("unmapped write", rs, ATAST_RESP_ERR);
        axi_rd(8'h24, d, rs);
        check("unmapped read resp", rs, ATAST_RESP_ERR);
        check("unmapped read data", d, ATAST_ZERO32);
    endtask
    task automatic sc_override_off();
        int ns, nh;
        do_access(1'b0, 1'b1, 1'b0, 8'h09, 8'h09, 8'h09, 16'h1234, ns, nh);
        check("off strobe cycles", ns, 1);
        check("off hold cycles", nh, 1);
        recover_chk(1'b0);
    endtask
    // strobe plus recovery cover the cycle time, hold covers worst write
    task automatic sc_pio_write();
        int ns, nh;
        do_access(1'b0, 1'b1, 1'b1, 8'h03, 8'h13, 8'h02, 16'hA5C3, ns, nh);
        check("pio strobe cycles", ns, 4);
        check("pio hold cycles", nh, 3);
        check("disk write word", last_wr, 16'hA5C3);
        recover_chk(1'b1);
    endtask
    task automatic sc_read(input logic dma, input logic [7:0] s,
                           input logic [15:0] w);
        int          ns, nh;
        logic [31:0] d;
        logic [1:0]  rs;
        word <= w;
        do_access(dma, 1'b0, 1'b1, s, 8'h13, 8'h05, 16'h0000, ns, nh);
        check("read strobe cycles", ns, s + 1);
        check("read hold cycles", nh, 0);
        recover_chk(1'b1);
        axi_rd(ATAST_OFF_RDATA, d, rs);
        check("read word", d, {16'h0000, w});
    endtask
    task automatic sc_dma_write();
        int ns, nh;
        do_access(1'b1, 1'b1, 1'b1, 8'h05, 8'h0F, 8'h00, 16'h0FF0, ns, nh);
        check("dma strobe cycles", ns, 6);
        check("dma hold cycles", nh, 1);
        check("disk write word", last_wr, 16'h0FF0);
        recover_chk(1'b1);
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        word = 16'h0000;
        errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        sc_reset_vals();
        sc_unmapped();
        sc_override_off();
        sc_pio_write();
        sc_read(1'b0, 8'h06, 16'h5A0F);
        sc_dma_write();
        sc_read(1'b1, 8'h04, 16'h3C96);
        tally_and_finish();
    end
endmodule
